// >>> hw/cond_branch_resolve.sv
// module: decode and resolve conditional branches, own counter and link
// Function
// - counter form is opcode 19, extended 528
// - selector picks one condition register bit
// - counter target is counter with low bits cleared
// - link flag writes current address plus four
// - taken needs counter term and condition term
// - counter form without bit 2 invalid, still decrements
// - that invalid form branches to decremented counter
// - option 20 selector 0 always branches
// - options 12 and 4 test bit set, clear
// - field offset 3 serves overflow and unordered
// - link form is opcode 19, extended 16
// - link-flag variants update the link register
// - link target is link with low bits cleared
// - displacement shifted two, sign extended
// - absolute flag selects zero base, else current
module cond_branch_resolve
    import branch_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire branch_pkg::issue_s issue,
    input  wire logic [31:0]        condition_register,
    input  wire branch_pkg::spr_load_s spr_load,
    output branch_pkg::resolve_s    result,
    output logic [31:0]             count_register,
    output logic [31:0]             link_register
);
    import branch_pkg::*;

    state_s      st_ff;               // registered state
    state_s      nxt_st;              // next state
    kind_e       kind;                // decoded branch form
    logic [4:0]  branch_options;      // option field
    logic [4:0]  condition_selector;  // condition bit index
    logic [4:0]  reserved_bits;       // must be zero in register forms
    logic [13:0] branch_displacement; // relative displacement
    logic        absolute_address_flag;
    logic        link_flag;
    logic        sel_bit;             // chosen condition bit
    logic        taken;               // decision from the evaluator
    logic [31:0] count_dec;           // counter after optional decrement
    logic [31:0] seq_addr;            // fall-through address
    logic [31:0] disp;                // extended displacement
    logic [31:0] base;                // relative base
    logic [31:0] target;              // taken target

    // field extraction
    always_comb begin
        kind                  = decode_kind(issue.instr);
        branch_options        = issue.instr[BO_MSB:BO_LSB];
        condition_selector    = issue.instr[BI_MSB:BI_LSB];
        reserved_bits         = issue.instr[RSV_MSB:RSV_LSB];
        branch_displacement   = issue.instr[BD_MSB:BD_LSB];
        absolute_address_flag = issue.instr[AA_BIT];
        link_flag             = issue.instr[LK_BIT];
        // selector 0 is the msb; offset 3 of a field needs no special case
        sel_bit = condition_register[CR_TOP_IDX
                                     - condition_selector];
    end

    // counter and condition decision
    branch_cond_eval branch_cond_eval_inst (
        .branch_options (branch_options),
        .cond_bit       (sel_bit),
        .count_in       (st_ff.count_register),
        .count_out      (count_dec),
        .taken          (taken)
    );

    // target formation for each form
    always_comb begin
        seq_addr = issue.current_instruction_address + INSTR_STEP;
        // sign of the displacement field fills the upper half
        disp = {{16{branch_displacement[13]}},
                branch_displacement, 2'b00};
        base = absolute_address_flag ? 32'h0000_0000 : issue.current_instruction_address;
        case (kind)
            KIND_REL: begin
                target = base + disp;
            end
            KIND_CTR: begin
                // decremented value when the form is invalid
                target = {count_dec[31:2], 2'b00};
            end
            KIND_LR: begin
                target = {st_ff.link_register[31:2], 2'b00};
            end
            default: begin
                target = seq_addr;
            end
        endcase
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.res.valid        = 1'b0;
        nxt_st.res.taken        = 1'b0;
        nxt_st.res.invalid_form = 1'b0;
        // direct loads; a branch in the same cycle overrides the counter load, and the link load only when its link flag is set
        if (spr_load.ctr_we) begin
            nxt_st.count_register = spr_load.data;
        end
        if (spr_load.lr_we) begin
            nxt_st.link_register = spr_load.data;
        end
        if (issue.valid && (kind != KIND_NONE)) begin
            nxt_st.res.valid = 1'b1;
            nxt_st.res.taken = taken;
            nxt_st.res.next_fetch_address = taken ? target : seq_addr;
            nxt_st.count_register = count_dec;
            if (link_flag) begin
                nxt_st.link_register = seq_addr;
            end
            nxt_st.res.invalid_form =
                ((kind == KIND_CTR) && !branch_options[BO_NO_DECR])
                || ((kind != KIND_REL) && (reserved_bits != 5'h00));
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.res.valid              <= 1'b0;
            st_ff.res.taken              <= 1'b0;
            st_ff.res.invalid_form       <= 1'b0;
            st_ff.res.next_fetch_address <= RST_FETCH;
            st_ff.count_register         <= RST_COUNT;
            st_ff.link_register          <= RST_LINK;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign result         = st_ff.res;
    assign count_register = st_ff.count_register;
    assign link_register  = st_ff.link_register;

    // checks
    logic go;  // a branch is accepted this cycle
    assign go = clk_en && issue.valid && (kind != KIND_NONE);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_ctr_target;
        go && (kind == KIND_CTR) && taken
        |=> result.next_fetch_address == {count_register[31:2], 2'b00};
    endproperty
    a_ctr_target: assert property (p_ctr_target)
        else $error("counter target wrong");

    property p_link_write;
        go && link_flag |=> link_register == $past(seq_addr);
    endproperty
    a_link_write: assert property (p_link_write)
        else $error("link not written with return address");

    property p_fall_through;
        go && !taken
        |=> result.valid && !result.taken
            && result.next_fetch_address == $past(seq_addr);
    endproperty
    a_fall_through: assert property (p_fall_through)
        else $error("not-taken address wrong");

    property p_invalid_dec;
        go && (kind == KIND_CTR) && !branch_options[BO_NO_DECR]
        |=> result.invalid_form
            && count_register == $past(count_register) - 32'h0000_0001;
    endproperty
    a_invalid_dec: assert property (p_invalid_dec)
        else $error("invalid counter form mishandled");

    property p_always;
        go && (kind == KIND_CTR) && (branch_options == BO_ALWAYS)
        && (condition_selector == 5'h00)
        |=> result.taken && count_register == $past(count_register)
            && result.next_fetch_address[1:0] == 2'b00;
    endproperty
    a_always: assert property (p_always)
        else $error("always form not taken or counter moved");

    property p_cond_set;
        go && (kind != KIND_NONE) && (branch_options == 5'h0c)
        |=> result.taken == $past(sel_bit);
    endproperty
    a_cond_set: assert property (p_cond_set)
        else $error("condition test wrong");

    property p_lr_target;
        go && (kind == KIND_LR) && taken
        |=> result.next_fetch_address == {$past(st_ff.link_register[31:2]),
                                          2'b00};
    endproperty
    a_lr_target: assert property (p_lr_target)
        else $error("link target wrong");

    property p_abs_target;
        go && (kind == KIND_REL) && taken && absolute_address_flag
        |=> result.next_fetch_address == $past(disp);
    endproperty
    a_abs_target: assert property (p_abs_target)
        else $error("absolute target wrong");

    property p_reserved;
        go && (kind == KIND_LR) && (reserved_bits != 5'h00)
        |=> result.invalid_form;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not flagged");

    // counter form is recognised from the raw opcode fields
    property p_ctr_decode;
        clk_en && issue.valid
        && (issue.instr[OPCD_MSB:OPCD_LSB] == OPCD_EXT)
        && (issue.instr[XO_MSB:XO_LSB] == XO_CTR)
        |=> result.valid;
    endproperty
    a_ctr_decode: assert property (p_ctr_decode)
        else $error("counter form not recognised");

    // link form is recognised from the raw opcode fields
    property p_lr_decode;
        clk_en && issue.valid
        && (issue.instr[OPCD_MSB:OPCD_LSB] == OPCD_EXT)
        && (issue.instr[XO_MSB:XO_LSB] == XO_LR)
        |=> result.valid;
    endproperty
    a_lr_decode: assert property (p_lr_decode)
        else $error("link form not recognised");

    // relative target adds the displacement to the branch address
    property p_rel_target;
        go && (kind == KIND_REL) && taken && !absolute_address_flag
        |=> result.next_fetch_address == $past(issue.current_instruction_address) + $past(disp);
    endproperty
    a_rel_target: assert property (p_rel_target)
        else $error("relative target wrong");

    // without the link flag or a load the link value stays put
    property p_link_hold;
        go && !link_flag && !spr_load.lr_we
        |=> link_register == $past(link_register);
    endproperty
    a_link_hold: assert property (p_link_hold)
        else $error("link moved without link flag");

endmodule // cond_branch_resolve

// >>> common/branch_pkg.sv
// package: encodings, field positions, carriers and decode for branch resolve
package branch_pkg;

    // primary and extended opcodes
    localparam logic [5:0]  OPCD_REL   = 6'h10;       // relative conditional
    localparam logic [5:0]  OPCD_EXT   = 6'h13;       // register-target group
    localparam logic [9:0]  XO_CTR     = 10'h210;     // to count register
    localparam logic [9:0]  XO_LR      = 10'h010;     // to link register

    // instruction field positions (bit 0 of the word is its lsb here)
    localparam int OPCD_MSB = 31;
    localparam int OPCD_LSB = 26;
    localparam int BO_MSB   = 25;
    localparam int BO_LSB   = 21;
    localparam int BI_MSB   = 20;
    localparam int BI_LSB   = 16;
    localparam int RSV_MSB  = 15;
    localparam int RSV_LSB  = 11;
    localparam int BD_MSB   = 15;
    localparam int BD_LSB   = 2;
    localparam int XO_MSB   = 10;
    localparam int XO_LSB   = 1;
    localparam int AA_BIT   = 1;
    localparam int LK_BIT   = 0;

    // option bits, indexed as vector positions of branch_options
    localparam int BO_IGNORE_COND = 4;  // option bit 0
    localparam int BO_COND_VALUE  = 3;  // option bit 1
    localparam int BO_NO_DECR     = 2;  // option bit 2
    localparam int BO_ZERO_VALUE  = 1;  // option bit 3

    // vector index of the condition register msb
    localparam logic [4:0]  CR_TOP_IDX   = 5'h1f;
    // option value of the always-taken form
    localparam logic [4:0]  BO_ALWAYS    = 5'h14;
    // sequential step of the fetch address
    localparam logic [31:0] INSTR_STEP   = 32'h0000_0004;

    // reset values
    localparam logic [31:0] RST_COUNT    = 32'h0000_0000;
    localparam logic [31:0] RST_LINK     = 32'h0000_0000;
    localparam logic [31:0] RST_FETCH    = 32'h0000_0000;

    // branch form
    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_REL  = 2'b01,
        KIND_CTR  = 2'b10,
        KIND_LR   = 2'b11
    } kind_e;

    // one instruction offered for resolution
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] current_instruction_address;
    } issue_s;

    // direct writes of counter and link from elsewhere in the core
    typedef struct packed {
        logic        ctr_we;
        logic        lr_we;
        logic [31:0] data;
    } spr_load_s;

    // resolution result
    typedef struct packed {
        logic        valid;
        logic        taken;
        logic        invalid_form;
        logic [31:0] next_fetch_address;
    } resolve_s;

    // whole state of the resolve unit
    typedef struct packed {
        resolve_s    res;
        logic [31:0] count_register;
        logic [31:0] link_register;
    } state_s;

    // classify an instruction word
    function automatic kind_e decode_kind(input logic [31:0] instr);
        kind_e k;
        k = KIND_NONE;
        if (instr[OPCD_MSB:OPCD_LSB] == OPCD_REL) begin
            k = KIND_REL;
        end else if (instr[OPCD_MSB:OPCD_LSB] == OPCD_EXT) begin
            if (instr[XO_MSB:XO_LSB] == XO_CTR) begin
                k = KIND_CTR;
            end else if (instr[XO_MSB:XO_LSB] == XO_LR) begin
                k = KIND_LR;
            end
        end
        return k;
    endfunction

endpackage

// >>> hw/branch_cond_eval.sv
// module: counter decrement and taken decision from the option field
module branch_cond_eval
    import branch_pkg::*;
(
    input  wire logic [4:0]  branch_options,
    input  wire logic        cond_bit,
    input  wire logic [31:0] count_in,
    output logic [31:0]      count_out,
    output logic             taken
);
    logic ctr_ok;   // counter term
    logic cond_ok;  // condition term

    // decrement first, then test the decremented value
    always_comb begin
        if (branch_options[BO_NO_DECR]) begin
            count_out = count_in;
        end else begin
            count_out = count_in - 32'h0000_0001;
        end
        ctr_ok  = branch_options[BO_NO_DECR]
                | ((count_out == 32'h0000_0000)
                   == branch_options[BO_ZERO_VALUE]);
        cond_ok = branch_options[BO_IGNORE_COND]
                | (cond_bit == branch_options[BO_COND_VALUE]);
        taken   = ctr_ok & cond_ok;
    end
endmodule // branch_cond_eval

// >>> test/conditional_branch_decode_tb.sv
// testbench: random and directed checks of conditional branch resolution
module conditional_branch_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import branch_pkg::*;

    logic        ref_clk;         // core clock
    logic        rst_n;           // async reset, active low
    logic        clk_en;          // state advance enable
    issue_s      issue;           // offered instruction
    logic [31:0] cr;              // condition register value
    spr_load_s   spr_load;        // side loads of counter and link
    resolve_s    result;          // resolution result
    logic [31:0] count_register;  // counter seen
    logic [31:0] link_register;   // link seen
    state_s      exp_st;          // expected state after the last edge
    logic [31:0] lfsr;            // random source
    int          n_fail;          // mismatches
    int          samples_checked; // comparisons made
    int          cycles;          // clock cycles run

    // option values of the common mnemonic forms
    localparam logic [4:0] BOS [8] = '{5'h14, 5'h0c, 5'h04, 5'h10,
                                       5'h12, 5'h00, 5'h02, 5'h0a};

    cond_branch_resolve cond_branch_resolve_inst (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .clk_en             (clk_en),
        .issue              (issue),
        .condition_register (cr),
        .spr_load           (spr_load),
        .result             (result),
        .count_register     (count_register),
        .link_register      (link_register)
    );

    // free running clock, 10 ns period
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // galois shift register, fixed start value
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h8020_0003 : 32'h0000_0000);
        return lfsr;
    endfunction

    // expected state after one enabled edge
    function automatic state_s model(state_s s, issue_s i, logic [31:0] c,
                                     spr_load_s ld);
        state_s      n;
        logic [4:0]  bo;
        logic [31:0] ctr;
        logic [31:0] tgt;
        logic        ok;
        logic        rel;
        logic        fc;
        logic        fl;
        n = s;
        n.res.valid = 1'b0;
        n.res.taken = 1'b0;
        n.res.invalid_form = 1'b0;
        if (ld.ctr_we) n.count_register = ld.data;
        if (ld.lr_we) n.link_register = ld.data;
        bo = i.instr[25:21];
        rel = i.instr[31:26] == 6'h10;
        fc = i.instr[31:26] == 6'h13 && i.instr[10:1] == 10'h210;
        fl = i.instr[31:26] == 6'h13 && i.instr[10:1] == 10'h010;
        if (i.valid && (rel || fc || fl)) begin
            ctr = s.count_register - {31'h0000_0000, ~bo[2]};
            ok = (bo[2] || ((ctr == 32'h0000_0000) == bo[1]))
                 && (bo[4] || (c[31 - i.instr[20:16]] == bo[3]));
            if (rel) begin
                tgt = (i.instr[1] ? 32'h0000_0000 : i.current_instruction_address)
                      + {{16{i.instr[15]}}, i.instr[15:2], 2'b00};
            end else begin
                tgt = fc ? ctr : s.link_register;
                tgt[1:0] = 2'b00;
            end
            n.count_register = ctr;
            if (i.instr[0]) n.link_register = i.current_instruction_address + 32'h0000_0004;
            n.res.valid = 1'b1;
            n.res.taken = ok;
            n.res.invalid_form = (fc && !bo[2])
                                 || (!rel && i.instr[15:11] != 5'h00);
            n.res.next_fetch_address = ok ? tgt : i.current_instruction_address + 32'h0000_0004;
        end
        return n;
    endfunction

    // compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // check the last edge, then drive the next cycle at the falling edge
    task automatic step(input issue_s i, input logic [31:0] c,
                        input spr_load_s ld, input logic en);
        @(negedge ref_clk);
        chk(result.valid, exp_st.res.valid);
        chk(result.taken, exp_st.res.taken);
        chk(result.invalid_form, exp_st.res.invalid_form);
        chk(result.next_fetch_address,
            exp_st.res.next_fetch_address);
        chk(count_register, exp_st.count_register);
        chk(link_register, exp_st.link_register);
        issue = i;
        cr = c;
        spr_load = ld;
        clk_en = en;
        if (en) exp_st = model(exp_st, i, c, ld);
    endtask

    // verdict and end of run
    task automatic results();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            results();
        end
    end

    // directed corner cases: word, condition register, load value
    localparam logic [31:0] DI [9] = '{32'h4e80_0420, 32'h4e80_0421,
        32'h4e00_0420, 32'h4e00_0420, 32'h4d83_0420, 32'h4c83_0420,
        32'h4e80_0020, 32'h4280_fffe, 32'h4e80_0c20};
    localparam logic [31:0] DC [9] = '{32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h1000_0000, 32'h1000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    localparam logic [31:0] DD [9] = '{32'h0000_2000, 32'h0000_2000,
        32'h0000_2004, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
        32'h0000_3003, 32'h0000_0000, 32'h0000_0040};

    // main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] w;
        logic [31:0] d;
        logic [4:0]  bo;
        logic [31:0] ins;
        rst_n = 1'b0;
        clk_en = 1'b1;
        issue = '0;
        cr = 32'h0000_0000;
        spr_load = '0;
        exp_st = '0;
        lfsr = 32'h0001_0d99;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        // load counter and link, then issue the word back to back
        for (int k = 0; k < 9; k++) begin
            step('0, 32'h0000_0000, '{1'b1, 1'b1, DD[k]}, 1'b1);
            step('{1'b1, DI[k], 32'h0000_0100}, DC[k], '0, 1'b1);
        end
        // random mix of the three forms and foreign words
        for (int k = 0; k < 3000; k++) begin
            r = rnd();
            w = rnd();
            d = rnd();
            bo = r[2] ? BOS[r[5:3]] : w[25:21];
            case (r[1:0])
                2'd0: ins = {6'h10, bo, w[20:0]};
                2'd1: ins = {6'h13, bo, w[20:16], r[8] ? w[15:11] : 5'h00,
                             10'h210, w[0]};
                2'd2: ins = {6'h13, bo, w[20:16], r[8] ? w[15:11] : 5'h00,
                             10'h010, w[0]};
                default: ins = w;
            endcase
            step('{r[21] | r[22], ins, {r[31:2], 2'b00}}, rnd(),
                 '{r[11:9] == 3'h0, r[14:12] == 3'h0,
                   r[16] ? {30'h0000_0000, d[1:0]} : d},
                 r[20:18] != 3'h0);
        end
        step('0, 32'h0000_0000, '0, 1'b1);
        step('0, 32'h0000_0000, '0, 1'b1);
        results();
    end

endmodule // conditional_branch_decode_tb
